// [design/dmes_pkg.sv]
// Shared constants and carrier types for the delay-mode error status bank
package dmes_pkg;

  // Channel count of the bank
  localparam int unsigned NUM_CH = 2;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_ERR_CH0 = 8'h00;
  localparam logic [7:0] OFS_ERR_CH1 = 8'h08;
  localparam logic [7:0] OFS_CTRL_CH0 = 8'h10;
  localparam logic [7:0] OFS_CTRL_CH1 = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // Error byte bit positions
  localparam int unsigned BIT_UV = 0;
  localparam int unsigned BIT_SENSOR = 1;
  localparam int unsigned BIT_LOAD = 2;
  localparam int unsigned BIT_PULSE = 3;
  localparam int unsigned BIT_OUT_A = 4;
  localparam int unsigned BIT_OUT_B = 5;
  localparam int unsigned BIT_SETPT = 6;
  localparam int unsigned BIT_SLOT = 7;

  // Control register bit positions
  localparam int unsigned CTL_CLEAR = 0;
  localparam int unsigned CTL_SRC = 1;
  localparam int unsigned CTL_MAN_A = 2;
  localparam int unsigned CTL_MAN_B = 3;
  localparam int unsigned CTL_SLOT_PERM = 4;

  // Configuration register bit positions
  localparam int unsigned CFG_TWO_CH = 0;

  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic TWO_CH_RST = 1'b1;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // Per-channel control bits, bit 0 first from the bottom
  typedef struct packed {
    logic slot_perm;
    logic manual_level_b;
    logic manual_level_a;
    logic output_source_select;
    logic error_clear_request;
  } dmes_ctrl_t;

  // Per-channel fault pins from the output stage
  typedef struct packed {
    logic supply_present;
    logic supply_low;
    logic sensor_short;
    logic pulse_fault;
    logic out_a_short;
    logic out_b_short;
  } dmes_pin_t;

  // Per-channel checks from same-clock slot logic
  typedef struct packed {
    logic load_fail;
    logic setpoint_invalid;
    logic slot_invalid;
  } dmes_chk_t;

endpackage : dmes_pkg

// [design/dmes_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module dmes_sync
  import dmes_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous in, filtered out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // Refuse an empty vector
  if (WIDTH < 1) begin : g_bad_width
    $error("dmes_sync needs WIDTH of at least one");
  end

  // Stage flops and the accepted value
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } dmes_sync_state_t;

  dmes_sync_state_t st_reg;
  dmes_sync_state_t st_next;

  // Shift, and take a bit once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q;

endmodule : dmes_sync

// [design/dmes_flags.sv]
// Error flag bank for two delay-mode pulse channels on an AHB-Lite slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps

// How it works
// - Bit 0 shows present but low supply
// - Absent supply keeps bit 0 clear
// - Bit 1 sets on sensor supply short
// - Bit 1 holds until clear; refuse slot loads
// - Bit 2 sets on failed single-update load
// - Bit 2 holds until clear; refuse slot loads
// - Bit 3 follows pulse output fault
// - Bit 4 latches output A short
// - Bit 5 latches B short or both-high manual
// - Bit 6 follows invalid setpoint
// - Bit 7 follows invalid slot, permanent mode only
// - Channel one byte only in two-channel config
module dmes_flags
  import dmes_pkg::*;
#(
  parameter logic TWO_CH_DEFAULT = TWO_CH_RST
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Fault pins, asynchronous to clock
  input wire dmes_pin_t [NUM_CH-1:0] fault_pins,
  // Slot and setpoint checks, same clock
  input wire dmes_chk_t [NUM_CH-1:0] value_checks,
  // Process image and control towards the channels
  output logic [NUM_CH-1:0][7:0] error_flags,
  output dmes_ctrl_t [NUM_CH-1:0] ctrl_out,
  output logic [NUM_CH-1:0] slot_load_refused,
  // Interrupt
  output logic irq
);

  // Only the two-channel layout is served
  if (NUM_CH != 2) begin : g_bad_ch
    $error("dmes_flags serves exactly two channels");
  end

  // Whole state of the bank
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] flags;
    dmes_ctrl_t [NUM_CH-1:0] ctrl;
    logic two_ch;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic irq;
    logic [NUM_CH-1:0] refuse;
    logic hready;
    logic hresp;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } dmes_state_t;

  dmes_state_t st_reg;
  dmes_state_t st_next;

  // Filtered pins
  dmes_pin_t [NUM_CH-1:0] pin_s;
  // Working copies inside the next-state logic
  logic acc;
  logic mapped;
  logic rd_clr;
  logic [15:0] ev;
  logic [7:0] f;
  dmes_pin_t p;
  dmes_chk_t v;
  dmes_ctrl_t k;

  // Pins pass four flops before use
  dmes_sync #(
    .WIDTH(NUM_CH * $bits(dmes_pin_t))
  ) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d(fault_pins),
    .q(pin_s)
  );

  // Control word from bus data
  function automatic dmes_ctrl_t ctrl_of(input logic [31:0] w);
    dmes_ctrl_t c;
    c.error_clear_request = w[CTL_CLEAR];
    c.output_source_select = w[CTL_SRC];
    c.manual_level_a = w[CTL_MAN_A];
    c.manual_level_b = w[CTL_MAN_B];
    c.slot_perm = w[CTL_SLOT_PERM];
    return c;
  endfunction : ctrl_of

  // Read multiplexer, unmapped reads give zero
  function automatic logic [31:0] rd_word(input dmes_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      OFS_ERR_CH0: w[7:0] = s.flags[0];
      OFS_ERR_CH1: w[7:0] = s.two_ch ? s.flags[1] : 8'h00;
      OFS_CTRL_CH0: w[4:0] = s.ctrl[0];
      OFS_CTRL_CH1: w[4:0] = s.ctrl[1];
      OFS_CONFIG: w[CFG_TWO_CH] = s.two_ch;
      OFS_IRQ_STAT: w[15:0] = s.irq_stat;
      OFS_IRQ_MASK: w[15:0] = s.irq_mask;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  // Next-state logic: bus slave, flags, interrupt
  always_comb begin
    st_next = st_reg;
    rd_clr = 1'b0;
    ev = 16'h0000;
    f = 8'h00;
    p = '0;
    v = '0;
    k = '0;
    // Zero-wait slave, always OKAY
    st_next.hready = 1'b1;
    st_next.hresp = HRESP_OKAY;
    st_next.wr_pend = 1'b0;
    acc = hsel && htrans[1] && hready;
    mapped = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    // Write data phase lands here
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        OFS_CTRL_CH0: st_next.ctrl[0] = ctrl_of(hwdata);
        OFS_CTRL_CH1: st_next.ctrl[1] = ctrl_of(hwdata);
        OFS_CONFIG: st_next.two_ch = hwdata[CFG_TWO_CH];
        OFS_IRQ_MASK: st_next.irq_mask = hwdata[15:0];
        default: st_next.wr_pend = 1'b0;
      endcase
    end
    // Address phase
    if (acc) begin
      if (hwrite) begin
        // Word writes only; others dropped
        st_next.wr_pend = mapped && (hsize == HSIZE_WORD);
        st_next.wr_addr = haddr[7:0];
      end else begin
        // Read data registered for the data phase
        st_next.rdata = mapped ? rd_word(st_reg, haddr[7:0]) : 32'h0000_0000;
        rd_clr = mapped && (haddr[7:0] == OFS_IRQ_STAT);
      end
    end
    // Per-channel flag update
    for (int c = 0; c < NUM_CH; c++) begin
      p = pin_s[c];
      v = value_checks[c];
      k = st_reg.ctrl[c];
      // Level flags
      f[BIT_UV] = p.supply_present && p.supply_low;
      f[BIT_PULSE] = p.pulse_fault;
      f[BIT_SETPT] = v.setpoint_invalid;
      f[BIT_SLOT] = v.slot_invalid && k.slot_perm;
      // Sticky flags; a live fault wins over the clear
      f[BIT_SENSOR] = p.sensor_short ||
        (st_reg.flags[c][BIT_SENSOR] && !k.error_clear_request);
      f[BIT_LOAD] = (v.load_fail && !k.slot_perm) ||
        (st_reg.flags[c][BIT_LOAD] && !k.error_clear_request);
      f[BIT_OUT_A] = p.out_a_short ||
        (st_reg.flags[c][BIT_OUT_A] && !k.error_clear_request);
      f[BIT_OUT_B] = p.out_b_short ||
        (!k.output_source_select && k.manual_level_a && k.manual_level_b) ||
        (st_reg.flags[c][BIT_OUT_B] && !k.error_clear_request);
      // Second channel silent in single-channel config
      if ((c == 1) && !st_reg.two_ch) begin
        f = 8'h00;
      end
      st_next.flags[c] = f;
      // Slot loads refused while either load-blocking flag stands
      st_next.refuse[c] = f[BIT_SENSOR] || f[BIT_LOAD];
      // Rising flags become interrupt events
      ev[c*8 +: 8] = f & ~st_reg.flags[c];
    end
    // Sticky status, event beats read-clear
    st_next.irq_stat = ev | (st_reg.irq_stat & ~{16{rd_clr}});
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.ctrl <= {NUM_CH{CTRL_RST}};
      st_reg.two_ch <= TWO_CH_DEFAULT;
      st_reg.irq_mask <= IRQ_MASK_RST;
      st_reg.hready <= 1'b1;
      st_reg.hresp <= HRESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state
  assign hreadyout = st_reg.hready;
  assign hrdata = st_reg.rdata;
  assign hresp = st_reg.hresp;
  assign error_flags = st_reg.flags;
  assign ctrl_out = st_reg.ctrl;
  assign slot_load_refused = st_reg.refuse;
  assign irq = st_reg.irq;

  // Checks on channel zero, the same logic serves channel one; the single-config check is on channel one
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Sticky sensor flag standing with no clear
  sequence s_sensor_held;
    st_reg.flags[0][BIT_SENSOR] && !st_reg.ctrl[0].error_clear_request;
  endsequence

  // Clear asked while the short is gone
  sequence s_a_clear_ok;
    st_reg.ctrl[0].error_clear_request && !pin_s[0].out_a_short;
  endsequence

  // Single config held for two cycles
  sequence s_single_cfg;
    !st_reg.two_ch ##1 !st_reg.two_ch;
  endsequence

  // Output A flag rising over one edge
  sequence s_a_rise;
    !st_reg.flags[0][BIT_OUT_A] ##1 st_reg.flags[0][BIT_OUT_A];
  endsequence

  chk_uv_present_low: assert property (
    pin_s[0].supply_present && pin_s[0].supply_low |=> st_reg.flags[0][BIT_UV])
    else $error("undervoltage flag not set");

  chk_uv_absent_clear: assert property (
    !pin_s[0].supply_present |=> !st_reg.flags[0][BIT_UV])
    else $error("undervoltage flag set without supply");

  chk_sensor_short_set: assert property (
    pin_s[0].sensor_short |=> st_reg.flags[0][BIT_SENSOR] && st_reg.refuse[0])
    else $error("sensor fault flag or refusal missing");

  chk_sensor_flag_hold: assert property (
    s_sensor_held |=> st_reg.flags[0][BIT_SENSOR])
    else $error("sensor fault flag dropped without clear");

  chk_load_single_set: assert property (
    value_checks[0].load_fail && !st_reg.ctrl[0].slot_perm |=> st_reg.flags[0][BIT_LOAD])
    else $error("load fault flag not set");

  chk_load_perm_quiet: assert property (
    !st_reg.flags[0][BIT_LOAD] && st_reg.ctrl[0].slot_perm |=> !st_reg.flags[0][BIT_LOAD])
    else $error("load fault flag set in permanent mode");

  chk_load_refuse_tie: assert property (
    st_reg.refuse[0] == (st_reg.flags[0][BIT_SENSOR] || st_reg.flags[0][BIT_LOAD]))
    else $error("slot refusal disagrees with flags");

  chk_pulse_follow: assert property (
    ##1 st_reg.flags[0][BIT_PULSE] == $past(pin_s[0].pulse_fault))
    else $error("pulse fault flag does not follow");

  chk_out_a_clear: assert property (
    s_a_clear_ok |=> !st_reg.flags[0][BIT_OUT_A])
    else $error("output A flag not cleared");

  chk_out_a_hold: assert property (
    st_reg.flags[0][BIT_OUT_A] && !st_reg.ctrl[0].error_clear_request |=>
    st_reg.flags[0][BIT_OUT_A])
    else $error("output A flag dropped without clear");

  chk_manual_both: assert property (
    !st_reg.ctrl[0].output_source_select && st_reg.ctrl[0].manual_level_a &&
    st_reg.ctrl[0].manual_level_b |=> st_reg.flags[0][BIT_OUT_B])
    else $error("both-high manual drive not flagged");

  chk_setpoint_follow: assert property (
    $rose(value_checks[0].setpoint_invalid) |=> st_reg.flags[0][BIT_SETPT])
    else $error("setpoint flag does not follow");

  chk_slot_perm_only: assert property (
    !st_reg.ctrl[0].slot_perm |=> !st_reg.flags[0][BIT_SLOT])
    else $error("slot flag set outside permanent mode");

  chk_single_ch_zero: assert property (
    s_single_cfg |-> st_reg.flags[1] == 8'h00)
    else $error("channel one flags live in single config");

  chk_clear_keeps_live: assert property (
    st_reg.ctrl[0].error_clear_request && pin_s[0].out_a_short |=>
    st_reg.flags[0][BIT_OUT_A])
    else $error("clear dropped a live output A fault");

  chk_irq_event: assert property (
    s_a_rise |-> st_reg.irq_stat[BIT_OUT_A])
    else $error("rising output A flag left no status bit");

  chk_irq_from_mask: assert property (
    irq == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt disagrees with status and mask");

endmodule : dmes_flags

// [testbench/dmes_stage_model.sv]
// Behavioural channel output stage feeding fault levels to the bank
`timescale 1ns/1ps

module dmes_stage_model
  import dmes_pkg::*;
(
  // Clock
  input wire logic clock,
  // Levels commanded by the bench
  input wire dmes_pin_t [NUM_CH-1:0] pin_cmd,
  input wire dmes_chk_t [NUM_CH-1:0] chk_cmd,
  // Towards the bank
  output dmes_pin_t [NUM_CH-1:0] fault_pins,
  output dmes_chk_t [NUM_CH-1:0] value_checks
);
  // Stage reacts one edge after each command
  always @(posedge clock) begin
    fault_pins <= pin_cmd;
    value_checks <= chk_cmd;
  end
endmodule : dmes_stage_model

// [testbench/delay_mode_error_status_tb_top.sv]
// Self-checking bench for the delay-mode error status bank
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module delay_mode_error_status_tb_top
  import dmes_pkg::*;
;
  // Clock, reset and bus
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // Channel side
  dmes_pin_t [NUM_CH-1:0] pin_cmd, fault_pins;
  dmes_chk_t [NUM_CH-1:0] chk_cmd, value_checks;
  logic [NUM_CH-1:0][7:0] error_flags;
  dmes_ctrl_t [NUM_CH-1:0] ctrl_out;
  logic [NUM_CH-1:0] slot_load_refused;
  // Bookkeeping
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [7:0] bitpos [4] = '{8'h02, 8'h10, 8'h20, 8'h04};

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // 125 MHz clock
  always #4 clock = ~clock;

  dmes_stage_model stage (.clock(clock), .pin_cmd(pin_cmd), .chk_cmd(chk_cmd),
    .fault_pins(fault_pins), .value_checks(value_checks));

  dmes_flags dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .fault_pins(fault_pins), .value_checks(value_checks),
    .error_flags(error_flags), .ctrl_out(ctrl_out), .slot_load_refused(slot_load_refused),
    .irq(irq));

  // Verdict and end of run
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  // One single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, HRESP_OKAY)
  endtask : bus

  // Write with undefined upper bits kept zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask : rd_chk

  // Control word of one channel
  task automatic ctl(input int c, input logic [4:0] d);
    wr(c ? OFS_CTRL_CH1 : OFS_CTRL_CH0, {27'h0, d});
  endtask : ctl

  // Let a pin change cross the synchroniser
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle

  // Drive one sticky cause on a channel
  task automatic cause(input int c, input int k, input logic x);
    case (k)
      0: pin_cmd[c].sensor_short <= x;
      1: pin_cmd[c].out_a_short <= x;
      2: pin_cmd[c].out_b_short <= x;
      default: chk_cmd[c].load_fail <= x;
    endcase
    // Two edges, so the pin filter sees the level agree
    repeat (2) @(posedge clock);
  endtask : cause

  // Expected level-type bits of one error byte
  function automatic logic [7:0] lvl(dmes_pin_t p, dmes_chk_t k, logic perm);
    lvl = 8'h00;
    lvl[BIT_UV] = p.supply_present & p.supply_low;
    lvl[BIT_PULSE] = p.pulse_fault;
    lvl[BIT_SETPT] = k.setpoint_invalid;
    lvl[BIT_SLOT] = k.slot_invalid & perm;
  endfunction : lvl

  // Main sequence
  initial begin
    logic [NUM_CH-1:0] perm;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    pin_cmd = '0;
    chk_cmd = '0;
    void'($urandom(72321));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    // Reset values, read-only and unmapped places
    rd_chk(OFS_CONFIG, 32'h1);
    rd_chk(OFS_IRQ_MASK, 32'h0);
    rd_chk(OFS_CTRL_CH1, 32'h0);
    wr(OFS_ERR_CH0, 32'hff);
    rd_chk(OFS_ERR_CH0, 32'h0);
    rd_chk(8'h24, 32'h0);
    // Random level faults on both channels
    for (int i = 0; i < 16; i++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        pin_cmd[c] <= dmes_pin_t'(6'($urandom) & 6'h34);
        chk_cmd[c] <= dmes_chk_t'(3'($urandom) & 3'h3);
        perm[c] = 1'($urandom);
        ctl(c, {perm[c], 4'h0});
      end
      settle();
      for (int c = 0; c < NUM_CH; c++) begin
        `CHK(error_flags[c], lvl(pin_cmd[c], chk_cmd[c], perm[c]))
        rd_chk(c ? OFS_ERR_CH1 : OFS_ERR_CH0, {24'h0, lvl(pin_cmd[c], chk_cmd[c], perm[c])});
      end
      `CHK(irq, 1'b0)
    end
    pin_cmd <= '0;
    chk_cmd <= '0;
    for (int c = 0; c < NUM_CH; c++) begin
      ctl(c, 5'h00);
    end
    settle();
    bus(1'b0, OFS_IRQ_STAT, 32'h0, v);
    // Sticky flags: hold, bits 1 and 2 refuse loads; the three pin-driven ones survive clear while cause lives
    for (int c = 0; c < NUM_CH; c++) begin
      for (int k = 0; k < 4; k++) begin
        cause(c, k, 1'b1);
        cause(c, k, 1'b0);
        settle();
        `CHK(error_flags[c], bitpos[k])
        `CHK(slot_load_refused[c], (k == 0 || k == 3))
        if (k < 3) begin
          cause(c, k, 1'b1);
          settle();
          ctl(c, 5'h01);
          settle();
          `CHK(error_flags[c], bitpos[k])
          cause(c, k, 1'b0);
        end else begin
          ctl(c, 5'h01);
        end
        settle();
        `CHK(error_flags[c], 8'h00)
        ctl(c, 5'h00);
      end
      // Failed load in permanent mode leaves bit 2 clear
      ctl(c, 5'h10);
      cause(c, 3, 1'b1);
      cause(c, 3, 1'b0);
      settle();
      `CHK(error_flags[c], 8'h00)
      // Both outputs driven high by hand
      ctl(c, 5'h0c);
      settle();
      `CHK(ctrl_out[c], dmes_ctrl_t'(5'h0c))
      `CHK(error_flags[c][BIT_OUT_B], 1'b1)
      ctl(c, 5'h01);
      ctl(c, 5'h00);
      settle();
      `CHK(error_flags[c], 8'h00)
    end
    // Interrupt raise, mask and read-clear
    bus(1'b0, OFS_IRQ_STAT, 32'h0, v);
    wr(OFS_IRQ_MASK, 32'h0010);
    pin_cmd[1].out_a_short <= 1'b1;
    settle();
    `CHK(irq, 1'b0)
    pin_cmd[0].out_a_short <= 1'b1;
    settle();
    `CHK(irq, 1'b1)
    rd_chk(OFS_IRQ_STAT, 32'h1010);
    `CHK(irq, 1'b0)
    pin_cmd <= '0;
    ctl(0, 5'h01);
    ctl(1, 5'h01);
    settle();
    // Single-channel configuration hides the second byte
    pin_cmd[1].pulse_fault <= 1'b1;
    wr(OFS_CONFIG, 32'h0);
    settle();
    `CHK(error_flags[1], 8'h00)
    rd_chk(OFS_ERR_CH1, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    settle();
    rd_chk(OFS_ERR_CH1, 32'h08);
    give_verdict();
  end
endmodule : delay_mode_error_status_tb_top
